// ==== pkg/bccr_pkg.sv ====
// Register map, field layout and reset values of the bridge capability registers.
// Assumes a 32-bit configuration access port with byte offsets.
package bccr_pkg;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h80;
    localparam logic [7:0] ADDR_SLOT_CAP = 8'hB0;
    localparam logic [7:0] ADDR_POWER_CAP = 8'hDC;
    localparam logic [7:0] ADDR_POWER_CTRL = 8'hE0;
    localparam logic [7:0] ADDR_LAST_CAP = 8'hE4;

    localparam logic [15:0] TIMEOUT_RESET = 16'h8000;

    localparam logic [7:0] CAP_ID_POWER = 8'h01;
    localparam logic [7:0] CAP_ID_GRAPHICS = 8'h02;
    localparam logic [7:0] CAP_ID_VPD = 8'h03;
    localparam logic [7:0] CAP_ID_SLOT = 8'h04;
    localparam logic [7:0] CAP_ID_MSI = 8'h05;
    localparam logic [7:0] CAP_ID_HOT_SWAP = 8'h06;

    localparam logic [7:0] NEXT_LINK_END = 8'h00;
    localparam logic [7:0] POWER_NEXT_LINK = 8'h0B;
    localparam logic [2:0] POWER_REVISION = 3'h1;

    localparam logic [4:0] SLOT_NUM_RESET = 5'h00;
    localparam logic [7:0] CHASSIS_RESET = 8'h00;

    localparam logic [1:0] PSTATE_D0 = 2'h0;
    localparam logic [1:0] PSTATE_D1 = 2'h1;
    localparam logic [1:0] PSTATE_D2 = 2'h2;
    localparam logic [1:0] PSTATE_D3 = 2'h3;

    localparam int CHIP_RESET_CYCLES = 4;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bccr_req_t;

    typedef struct packed {
        logic [7:0] chassis;
        logic [1:0] reserved;
        logic first_in_chassis;
        logic [4:0] slot_number;
        logic [7:0] next_link;
        logic [7:0] identifier;
    } bccr_slot_word_t;

    typedef struct packed {
        logic [4:0] wake_support;
        logic d2_support;
        logic d1_support;
        logic [2:0] reserved;
        logic dev_init;
        logic aux_power;
        logic wake_clock;
        logic [2:0] revision;
        logic [7:0] next_link;
        logic [7:0] identifier;
    } bccr_power_cap_word_t;

    typedef struct packed {
        logic [15:0] upper;
        logic wake_status;
        logic [1:0] data_scale;
        logic [3:0] data_select;
        logic wake_enable;
        logic [5:0] reserved;
        logic [1:0] power_state;
    } bccr_power_ctrl_word_t;
endpackage : bccr_pkg

// ==== rtl/bccr_chip_reset.sv ====
// Stretches a one-cycle chip reset request into a fixed-length internal reset pulse.
// Assumes the request comes from the register bank in the same clock domain.
`timescale 1ns/1ps
module bccr_chip_reset #(
    parameter int CYCLES = bccr_pkg::CHIP_RESET_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_request,
    output logic o_chip_reset
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count_q;

    initial begin
        if (CYCLES < 1) begin
            $error("CYCLES must be at least one");
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            count_q <= '0;
        end else if (i_request) begin
            count_q <= CW'(CYCLES);
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_chip_reset <= 1'b0;
        end else begin
            o_chip_reset <= i_request || (count_q > CW'(1));
        end
    end
endmodule : bccr_chip_reset

// ==== rtl/bccr_regs.sv ====
// Configuration register group of a bridge: master timeouts, slot identification,
// power management capability and the terminating capability header.
// Assumes a single-clock master that never issues read and write together.
//
// Contract
// - Primary master timeout is a 16-bit RW field in bits 15:0, reset 8000h.
// - Secondary master timeout is a 16-bit RW field in bits 31:16, reset 8000h.
// - The slot last_cap_identifier byte is read-only and returns the slot identification code.
// - The slot capability next link is read-only and returns 00h for the documented straps.
// - Slot number bits 20:16 and chassis number bits 31:24 are RW and reset to zero.
// - The first-in-chassis flag at bit 21 is RW and resets to zero.
// - Bits 23:22 of the slot word are reserved and read zero.
// - The power last_cap_identifier byte is read-only and returns 01h.
// - The power capability next link is read-only and points at the slot capability; the code returns 0Bh, not the slot offset B0h.
// - The power management revision field in bits 18:16 reads 001.
// - Wake, auxiliary power, init, reserved, D1, D2 and wake support bits read zero.
// - The 2-bit power state field is RW, shows the current state, and resets to D0.
// - A write of an unimplemented power state completes but leaves the field unchanged.
// - A write moving the power state from D3 to D0 resets the chip, not the secondary bus.
// - Reserved, wake enable, data select, data scale and wake status bits read zero.
// - The final capability header has a read-only ID and a next link of 00h.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module bccr_regs #(
    parameter logic [7:0] LAST_CAP_ID = bccr_pkg::CAP_ID_HOT_SWAP,
    parameter int RESET_CYCLES = bccr_pkg::CHIP_RESET_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_mode_strap_zero,
    input wire logic i_mode_strap_one,
    output logic [31:0] o_rdata,
    output logic [15:0] o_primary_timeout,
    output logic [15:0] o_secondary_timeout,
    output logic [1:0] o_power_state,
    output logic o_chip_reset,
    output logic o_secondary_bus_reset
);
    bccr_pkg::bccr_req_t req;
    logic [15:0] prim_timeout_q;
    logic [15:0] sec_timeout_q;
    logic [4:0] slot_number_q;
    logic first_in_chassis_q;
    logic [7:0] chassis_q;
    logic [1:0] power_state_q;
    logic chip_reset_req_d;
    logic chip_reset;
    logic bank_reset;
    logic [7:0] slot_next_link;
    logic pstate_ok;
    bccr_pkg::bccr_slot_word_t slot_word;
    bccr_pkg::bccr_power_cap_word_t power_cap_word;
    bccr_pkg::bccr_power_ctrl_word_t power_ctrl_word;
    logic [31:0] rdata_d;
    logic sel_timeout;
    logic sel_slot;
    logic sel_power_cap;
    logic sel_power_ctrl;
    logic sel_last_cap;
    logic wr_timeout;
    logic wr_slot;
    logic wr_power_ctrl;
    logic pstate_write;
    logic leaving_d3;

    initial begin
        if (RESET_CYCLES < 1) begin
            $error("RESET_CYCLES must be at least one");
        end
        if (LAST_CAP_ID == bccr_pkg::NEXT_LINK_END) begin
            $error("LAST_CAP_ID must not be the reserved code");
        end
        if (LAST_CAP_ID > bccr_pkg::CAP_ID_HOT_SWAP) begin
            $error("LAST_CAP_ID must be a defined capability code");
        end
    end

    assign req.addr = i_addr;
    assign req.wdata = i_wdata;
    assign req.wr = i_wr;
    assign req.rd = i_rd;

    // Internal chip reset reloads every field register like the external reset
    assign bank_reset = i_reset || chip_reset;

    // One select per mapped word; an unmapped offset selects nothing and reads zero
    always_comb begin
        sel_timeout = 1'b0;
        sel_slot = 1'b0;
        sel_power_cap = 1'b0;
        sel_power_ctrl = 1'b0;
        sel_last_cap = 1'b0;
        if (req.addr == bccr_pkg::ADDR_TIMEOUT) begin
            sel_timeout = 1'b1;
        end else if (req.addr == bccr_pkg::ADDR_SLOT_CAP) begin
            sel_slot = 1'b1;
        end else if (req.addr == bccr_pkg::ADDR_POWER_CAP) begin
            sel_power_cap = 1'b1;
        end else if (req.addr == bccr_pkg::ADDR_POWER_CTRL) begin
            sel_power_ctrl = 1'b1;
        end else if (req.addr == bccr_pkg::ADDR_LAST_CAP) begin
            sel_last_cap = 1'b1;
        end
    end

    // Only words with writable fields get a write enable
    assign wr_timeout = req.wr && sel_timeout;
    assign wr_slot = req.wr && sel_slot;
    assign wr_power_ctrl = req.wr && sel_power_ctrl;
    // Writes of 01 or 10 never reach the field
    assign pstate_write = wr_power_ctrl && pstate_ok;
    // Only a write that starts from D3 may wake the chip
    assign leaving_d3 = wr_power_ctrl && power_state_q == bccr_pkg::PSTATE_D3;

    always_ff @(posedge i_clk) begin
        if (bank_reset) begin
            prim_timeout_q <= bccr_pkg::TIMEOUT_RESET;
        end else if (wr_timeout) begin
            prim_timeout_q <= req.wdata[15:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (bank_reset) begin
            sec_timeout_q <= bccr_pkg::TIMEOUT_RESET;
        end else if (wr_timeout) begin
            sec_timeout_q <= req.wdata[31:16];
        end
    end

    always_ff @(posedge i_clk) begin
        if (bank_reset) begin
            slot_number_q <= bccr_pkg::SLOT_NUM_RESET;
            chassis_q <= bccr_pkg::CHASSIS_RESET;
        end else if (wr_slot) begin
            slot_number_q <= req.wdata[20:16];
            chassis_q <= req.wdata[31:24];
        end
    end

    always_ff @(posedge i_clk) begin
        if (bank_reset) begin
            first_in_chassis_q <= 1'b0;
        end else if (wr_slot) begin
            first_in_chassis_q <= req.wdata[21];
        end
    end

    // Only D0 and D3 are accepted
    assign pstate_ok = (req.wdata[1:0] == bccr_pkg::PSTATE_D0)
        || (req.wdata[1:0] == bccr_pkg::PSTATE_D3);

    // Power state holds the current state
    always_ff @(posedge i_clk) begin
        if (bank_reset) begin
            power_state_q <= bccr_pkg::PSTATE_D0;
        end else if (pstate_write) begin
            power_state_q <= req.wdata[1:0];
        end
    end

    // D3 to D0 requests chip reset
    always_comb begin
        chip_reset_req_d = leaving_d3 && req.wdata[1:0] == bccr_pkg::PSTATE_D0;
    end

    bccr_chip_reset #(
        .CYCLES(RESET_CYCLES)
    ) u_chip_reset (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_request(chip_reset_req_d),
        .o_chip_reset(chip_reset)
    );

    // Next link ends the list for the listed straps
    always_comb begin
        if (i_mode_strap_zero || i_mode_strap_one) begin
            slot_next_link = bccr_pkg::NEXT_LINK_END;
        end else begin
            // Strap combination not covered; the list still ends here
            slot_next_link = bccr_pkg::NEXT_LINK_END;
        end
    end

    always_comb begin
        slot_word = '0;
        slot_word.identifier = bccr_pkg::CAP_ID_SLOT;
        slot_word.next_link = slot_next_link;
        slot_word.slot_number = slot_number_q;
        slot_word.first_in_chassis = first_in_chassis_q;
        slot_word.reserved = 2'h0;
        slot_word.chassis = chassis_q;
    end

    always_comb begin
        power_cap_word = '0;
        power_cap_word.identifier = bccr_pkg::CAP_ID_POWER;
        power_cap_word.next_link = bccr_pkg::POWER_NEXT_LINK;
        power_cap_word.revision = bccr_pkg::POWER_REVISION;
        power_cap_word.wake_clock = 1'b0;
        power_cap_word.aux_power = 1'b0;
        power_cap_word.dev_init = 1'b0;
        power_cap_word.reserved = 3'h0;
        power_cap_word.d1_support = 1'b0;
        power_cap_word.d2_support = 1'b0;
        power_cap_word.wake_support = 5'h00;
    end

    always_comb begin
        power_ctrl_word = '0;
        power_ctrl_word.power_state = power_state_q;
        power_ctrl_word.reserved = 6'h00;
        power_ctrl_word.wake_enable = 1'b0;
        power_ctrl_word.data_select = 4'h0;
        power_ctrl_word.data_scale = 2'h0;
        power_ctrl_word.wake_status = 1'b0;
    end

    // Read-only fields come only from constants
    always_comb begin
        if (sel_timeout) begin
            rdata_d = {sec_timeout_q, prim_timeout_q};
        end else if (sel_slot) begin
            rdata_d = slot_word;
        end else if (sel_power_cap) begin
            rdata_d = power_cap_word;
        end else if (sel_power_ctrl) begin
            rdata_d = power_ctrl_word;
        end else if (sel_last_cap) begin
            rdata_d = {16'h0000, bccr_pkg::NEXT_LINK_END, LAST_CAP_ID};
        end else begin
            rdata_d = 32'h0000_0000;
        end
    end

    // Read data stands only in the cycle after the strobe
    // The chip reset leaves this alone so an answer already launched still arrives
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            o_rdata <= rdata_d;
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    assign o_primary_timeout = prim_timeout_q;
    assign o_secondary_timeout = sec_timeout_q;
    assign o_power_state = power_state_q;
    assign o_chip_reset = chip_reset;
    assign o_secondary_bus_reset = 1'b0;
endmodule : bccr_regs

// ==== verif/bccr_regs_props.sv ====
// Port-level checks of the bridge capability register bank.
// Assumes one clock domain and a bind onto every bccr_regs instance.
`timescale 1ns/1ps
module bccr_regs_props #(
    parameter logic [7:0] LAST_CAP_ID = bccr_pkg::CAP_ID_HOT_SWAP,
    parameter int RESET_CYCLES = bccr_pkg::CHIP_RESET_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [15:0] o_primary_timeout,
    input wire logic [15:0] o_secondary_timeout,
    input wire logic [1:0] o_power_state,
    input wire logic o_chip_reset,
    input wire logic o_secondary_bus_reset
);
    logic [7:0] pulse_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Length of the running chip reset pulse
    always_ff @(posedge i_clk) begin
        if (i_reset || !o_chip_reset) begin
            pulse_q <= 8'h00;
        end else begin
            pulse_q <= pulse_q + 8'h01;
        end
    end
    AST_TIMEOUT_DEFAULT: assert property (($fell(i_reset) || $fell(o_chip_reset)) |->
        o_primary_timeout == 16'h8000 && o_secondary_timeout == 16'h8000) else $error("timeout default");
    AST_TIMEOUT_WRITE: assert property (i_wr && i_addr == 8'h80 && !o_chip_reset |=>
        {o_secondary_timeout, o_primary_timeout} == $past(i_wdata)) else $error("timeout write");
    AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h0) else $error("rdata not idle");
    AST_SLOT_FIXED: assert property (i_rd && i_addr == 8'hB0 |=>
        o_rdata[15:0] == 16'h0004 && o_rdata[23:22] == 2'b00) else $error("slot fixed bits");
    AST_POWER_CAP: assert property (i_rd && i_addr == 8'hDC |=>
        o_rdata == 32'h00010B01) else $error("power capability word");
    AST_POWER_CTRL_ZERO: assert property (i_rd && i_addr == 8'hE0 |=>
        o_rdata[31:2] == 30'h0 && o_rdata[1:0] == o_power_state) else $error("power control read");
    AST_PSTATE_WRITE: assert property (i_wr && i_addr == 8'hE0 && !o_chip_reset |=>
        o_power_state == (($past(i_wdata[1:0]) == 2'h1 || $past(i_wdata[1:0]) == 2'h2) ?
        $past(o_power_state) : $past(i_wdata[1:0]))) else $error("power state write");
    AST_WAKE_RESET: assert property (i_wr && i_addr == 8'hE0 && i_wdata[1:0] == 2'h0 &&
        o_power_state == 2'h3 |=> o_chip_reset) else $error("no chip reset");
    AST_PULSE_LENGTH: assert property ($fell(o_chip_reset) && !$past(i_reset) |->
        pulse_q == 8'(RESET_CYCLES)) else $error("chip reset length");
    AST_NO_BUS_RESET: assert property (!o_secondary_bus_reset) else $error("bus reset");
    AST_LAST_CAP: assert property (i_rd && i_addr == 8'hE4 |=>
        o_rdata == {24'h0, LAST_CAP_ID}) else $error("last capability word");
endmodule : bccr_regs_props

bind bccr_regs bccr_regs_props #(.LAST_CAP_ID(LAST_CAP_ID), .RESET_CYCLES(RESET_CYCLES)) i_props (
    .i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_primary_timeout,
    .o_secondary_timeout, .o_power_state, .o_chip_reset, .o_secondary_bus_reset);

// ==== verif/bccr_host_model.sv ====
// Configuration host driving the plain register port.
// Assumes the block answers a read in the cycle after the strobe.
`timescale 1ns/1ps
module bccr_host_model (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output bccr_pkg::bccr_req_t o_req
);
    initial o_req = '0;
    // Idle address and data are inverted so stale values cannot pass
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_req <= {a, d, 1'b1, 1'b0};
        @(posedge i_clk);
        o_req <= {~a, ~d, 2'b00};
        // Let the write settle so callers see the updated register
        #1;
    endtask : write
    task automatic read(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_req <= {a, 32'h0, 1'b0, 1'b1};
        @(posedge i_clk);
        o_req <= {~a, 32'hFFFFFFFF, 2'b00};
        @(posedge i_clk);
        d = i_rdata;
    endtask : read
endmodule : bccr_host_model

// ==== verif/bccr_regs_bench.sv ====
// Self-checking bench of the bridge capability register bank.
// Assumes bccr_pkg, bccr_regs and the host model are compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module bccr_regs_bench;
    // Non-default pulse length so a hard-wired count shows up
    localparam int RC = 3;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic strap0 = 1'b0;
    logic strap1 = 1'b1;
    logic [31:0] rdata, d;
    logic [15:0] pto, sto;
    logic [1:0] ps;
    logic crst, sbrst;
    int bad_count = 0;
    int tests_run = 0;
    bccr_pkg::bccr_req_t req;
    initial forever #2.5 clk = ~clk;
    bccr_host_model i_host (.i_clk(clk), .i_rdata(rdata), .o_req(req));
    bccr_regs #(.RESET_CYCLES(RC)) i_dut (.i_clk(clk), .i_reset(reset), .i_addr(req.addr),
        .i_wdata(req.wdata), .i_wr(req.wr), .i_rd(req.rd), .i_mode_strap_zero(strap0),
        .i_mode_strap_one(strap1), .o_rdata(rdata), .o_primary_timeout(pto),
        .o_secondary_timeout(sto), .o_power_state(ps), .o_chip_reset(crst),
        .o_secondary_bus_reset(sbrst));
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    task automatic t_defaults;
        i_host.read(8'h80, d);
        `CHK(d, 32'h80008000)
        i_host.read(8'hB0, d);
        `CHK(d, 32'h00000004)
        i_host.read(8'hDC, d);
        `CHK(d, 32'h00010B01)
        i_host.read(8'hE0, d);
        `CHK(d, 32'h00000000)
        i_host.read(8'hE4, d);
        `CHK(d, {24'h0, bccr_pkg::CAP_ID_HOT_SWAP})
        i_host.read(8'h84, d);
        `CHK(d, 32'h00000000)
        $display("test defaults done");
    endtask : t_defaults
    task automatic t_write_fields;
        i_host.write(8'h80, 32'h1234ABCD);
        `CHK({sto, pto}, 32'h1234ABCD)
        i_host.write(8'hB0, 32'hFFFFFFFF);
        for (int s = 1; s < 4; s++) begin
            strap0 <= s[0];
            strap1 <= s[1];
            i_host.read(8'hB0, d);
            `CHK(d, 32'hFF3F0004)
        end
        i_host.write(8'hB0, 32'h5A150000);
        i_host.read(8'hB0, d);
        `CHK(d, 32'h5A150004)
        i_host.write(8'hDC, 32'hFFFFFFFF);
        i_host.write(8'hE4, 32'hFFFFFFFF);
        i_host.read(8'hDC, d);
        `CHK(d, 32'h00010B01)
        i_host.read(8'hE4, d);
        `CHK(d, 32'h00000006)
        $display("test write fields done");
    endtask : t_write_fields
    task automatic t_power;
        int n;
        i_host.write(8'hE0, 32'hFFFFFFFF);
        i_host.read(8'hE0, d);
        `CHK(d, 32'h00000003)
        for (int v = 1; v < 3; v++) begin
            i_host.write(8'hE0, v);
            `CHK(ps, 2'h3)
        end
        i_host.write(8'hE0, 32'h0);
        n = 0;
        repeat (10) begin
            #1;
            if (crst === 1'b1) n++;
            `CHK(sbrst, 1'b0)
            @(posedge clk);
        end
        `CHK(n, RC)
        `CHK({ps, sto, pto}, {2'h0, 32'h80008000})
        i_host.read(8'hB0, d);
        `CHK(d, 32'h00000004)
        $display("test power done");
    endtask : t_power
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_defaults();
        t_write_fields();
        t_power();
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule : bccr_regs_bench
